// ---- logic/sp_reg_params.svh ----
// Function
// - companion count sits in bits 15..12
// - zero companions: no hand-off, high-speed only
// - nonzero companions: hand-off to companions supported
// - ports per companion in bits 11..8
// - ports per companion consistent with counts
// - rule bit clear: consecutive port groups routed
// - rule bit set: route from explicit array
// - bit 4 shows port power switches
// - port power behaviour follows capability bit
// - bits 3..0 give downstream port count
// - port count zero never reported
// - route array valid only with rule bit
`ifndef SP_REG_PARAMS_SVH
`define SP_REG_PARAMS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SP_OFFSET 8'h04
`define ROUTE_LO_OFFSET 8'h0c
`define ROUTE_HI_OFFSET 8'h10
// ****************************************
// field positions
// ****************************************
`define CC_LSB 12
`define PPC_LSB 8
`define PRR_BIT 7
`define PWR_BIT 4
`define PORTS_LSB 0
// ****************************************
// reset values
// ****************************************
`define CC_RESET 2
`define PPC_RESET 1
`define PRR_RESET 1
`define PWR_RESET 1
`define PORTS_RESET 2
`define ROUTE_RESET 60'h000000000000010
`endif

// ---- logic/sp_reg_pkg.sv ----
// ****************************************
// shared types
// ****************************************
package sp_reg_pkg;
    typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;
    typedef logic [3:0] nibble_t;
    typedef logic [31:0] word_t;
endpackage

// ---- logic/structural_parameters.sv ----
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sp_reg_params.svh"
module structural_parameters
    import sp_reg_pkg::*;
#(
    parameter int COMPANIONS = `CC_RESET,
    parameter int PORTS_PER = `PPC_RESET,
    parameter bit ROUTE_EXPLICIT = `PRR_RESET,
    parameter bit POWER_SWITCHES = `PWR_RESET,
    parameter int PORTS = `PORTS_RESET,
    parameter logic [59:0] ROUTE_TABLE = `ROUTE_RESET
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    output logic HANDOFF_EN,
    output logic PORT_POWER_SWITCHED,
    output logic [3:0] PORT_REG_COUNT,
    output logic [59:0] PORT_ROUTE
);
    // ****************************************
    // effective field values
    // ****************************************
    // a zero port count is undefined, so never let it reach the register
    localparam int PORTS_EFF = (PORTS == 0) ? 1 : PORTS;
    localparam int PPC_MIN = (COMPANIONS == 0) ? 0 :
        (PORTS_EFF + COMPANIONS - 1) / COMPANIONS;
    // widen ports per companion until every port has a home
    localparam int PPC_EFF = (PORTS_PER < PPC_MIN) ? PPC_MIN : PORTS_PER;
    localparam int PPC_DIV = (PPC_EFF == 0) ? 1 : PPC_EFF;
    localparam nibble_t CC_F = nibble_t'(COMPANIONS);
    localparam nibble_t PPC_F = nibble_t'(PPC_EFF);
    localparam nibble_t PORTS_F = nibble_t'(PORTS_EFF);

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta;
    logic rst_sync;

    // two flops so the release is clean against CLK
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ****************************************
    // register image
    // ****************************************
    word_t sp_word;
    logic [59:0] route_calc;

    // fixed fields; reserved bits are constant zero
    assign sp_word = {16'h0000, CC_F, PPC_F, ROUTE_EXPLICIT, 2'b00,
        POWER_SWITCHES, PORTS_F};

    // per-port companion choice
    for (genvar i = 0; i < 15; i++) begin : g_route
        if (i >= PORTS_EFF || COMPANIONS == 0) begin : g_none
            // no companions means no hand-off target
            assign route_calc[i*4 +: 4] = 4'h0;
        end else if (ROUTE_EXPLICIT) begin : g_explicit
            assign route_calc[i*4 +: 4] = ROUTE_TABLE[i*4 +: 4];
        end else begin : g_grouped
            // consecutive groups of PPC_DIV ports, lowest companion first
            assign route_calc[i*4 +: 4] = nibble_t'(i / PPC_DIV);
        end
    end

    // ****************************************
    // status outputs
    // ****************************************
    logic next_handoff;
    logic next_power;
    logic [3:0] next_count;
    logic [59:0] next_route;

    // held at safe values until reset is fully released
    always_comb begin
        next_handoff = 1'b0;
        next_power = 1'b0;
        next_count = 4'h0;
        next_route = 60'h0;
        if (rst_sync) begin
            next_handoff = (CC_F != 4'h0);
            next_power = POWER_SWITCHES;
            next_count = PORTS_F;
            next_route = route_calc;
        end
    end

    always_ff @(posedge CLK or negedge rst_sync) begin
        if (!rst_sync) begin
            HANDOFF_EN <= 1'b0;
            PORT_POWER_SWITCHED <= 1'b0;
            PORT_REG_COUNT <= 4'h0;
            PORT_ROUTE <= 60'h0;
        end else begin
            HANDOFF_EN <= next_handoff;
            PORT_POWER_SWITCHED <= next_power;
            PORT_REG_COUNT <= next_count;
            PORT_ROUTE <= next_route;
        end
    end

    // ****************************************
    // wishbone slave
    // ****************************************
    bus_state_t state;
    bus_state_t next_state;
    word_t next_dat;
    logic next_ack;
    logic req;

    assign req = CYC_I && STB_I;

    // one wait cycle then ack; writes are acked and dropped
    always_comb begin
        next_state = state;
        next_ack = 1'b0;
        next_dat = 32'h00000000;
        unique case (state)
            BUS_IDLE: begin
                if (req) begin
                    next_state = BUS_ACK;
                    next_ack = 1'b1;
                    if (!WE_I) begin
                        unique case (ADR_I)
                            `SP_OFFSET: next_dat = sp_word;
                            // route words hidden unless explicit routing
                            `ROUTE_LO_OFFSET: next_dat = ROUTE_EXPLICIT ?
                                route_calc[31:0] : 32'h0;
                            `ROUTE_HI_OFFSET: next_dat = ROUTE_EXPLICIT ?
                                {4'h0, route_calc[59:32]} : 32'h0;
                            default: next_dat = 32'h00000000;
                        endcase
                    end
                end
            end
            BUS_ACK: begin
                next_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= BUS_IDLE;
            ACK_O <= 1'b0;
            DAT_O <= 32'h00000000;
        end else begin
            state <= next_state;
            ACK_O <= next_ack;
            DAT_O <= next_dat;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_sync);

    sequence s_sp_read;
        req && !ACK_O && !WE_I && ADR_I == `SP_OFFSET;
    endsequence
    sequence s_sp_write;
        req && !ACK_O && WE_I && ADR_I == `SP_OFFSET;
    endsequence
    sequence s_lo_read;
        req && !ACK_O && !WE_I && ADR_I == `ROUTE_LO_OFFSET;
    endsequence

    a_ack_after_req: assert property (req && !ACK_O |=> ACK_O ##1 !ACK_O)
        else $error("ack not a single pulse after request");
    a_cc_field: assert property (s_sp_read |=> DAT_O[15:12] == CC_F)
        else $error("companion count field wrong");
    a_ppc_field: assert property (s_sp_read |=> DAT_O[11:8] == PPC_F)
        else $error("ports per companion field wrong");
    a_ppc_covers: assert property (s_sp_read |=>
        (DAT_O[15:12] == 4'h0) || (DAT_O[15:12] * DAT_O[11:8] >= {4'h0, DAT_O[3:0]}))
        else $error("ports per companion too small");
    a_power_bit: assert property (s_sp_read |=>
        DAT_O[4] == POWER_SWITCHES ##1 PORT_POWER_SWITCHED == POWER_SWITCHES)
        else $error("port power bit wrong");
    a_count_nonzero: assert property (s_sp_read |=> DAT_O[3:0] != 4'h0)
        else $error("port count reads zero");
    a_reserved_zero: assert property (s_sp_write ##[1:8] s_sp_read |=>
        DAT_O[31:16] == 16'h0 && DAT_O[6:5] == 2'b00 && DAT_O == sp_word)
        else $error("write changed read value");
    a_route_gated: assert property (s_lo_read |=>
        DAT_O == (ROUTE_EXPLICIT ? route_calc[31:0] : 32'h0))
        else $error("route word visible without explicit routing");
    a_handoff_state: assert property ($rose(rst_sync) ##2 1'b1 |->
        HANDOFF_EN == (COMPANIONS != 0) && PORT_REG_COUNT == PORTS_F)
        else $error("hand-off or port count output wrong");
    a_group_route: assert property (PORT_REG_COUNT != 4'h0 && !ROUTE_EXPLICIT &&
        COMPANIONS != 0 |-> PORT_ROUTE[3:0] == 4'h0)
        else $error("first port not on lowest companion");

    // ****************************************
    // bus framing checks
    // ****************************************
    sequence s_any_write;
        req && !ACK_O && WE_I;
    endsequence
    sequence s_hi_read;
        req && !ACK_O && !WE_I && ADR_I == `ROUTE_HI_OFFSET;
    endsequence

    // an ack must always answer a request seen on the edge before
    a_ack_has_req: assert property ($rose(ACK_O) |-> $past(req))
        else $error("ack without request");

    // writes are discarded, so nothing comes back on the data lines
    a_write_no_data: assert property (s_any_write |=> DAT_O == 32'h00000000)
        else $error("write returned data");

    // data lines rest at zero outside the ack cycle, so a stale word never leaks
    a_data_idle: assert property (!ACK_O |-> DAT_O == 32'h00000000)
        else $error("data not zero outside ack");

    // ****************************************
    // field consistency checks
    // ****************************************
    // hand-off output follows the companion count that software reads
    a_handoff_match: assert property (s_sp_read |=>
        (DAT_O[15:12] != 4'h0) == HANDOFF_EN)
        else $error("hand-off output disagrees with companion count");

    // the port register count and the read field must agree
    a_count_match: assert property (s_sp_read |=>
        DAT_O[3:0] == PORT_REG_COUNT)
        else $error("port count output disagrees with field");

    // no switched port power without the capability behind it
    a_power_level: assert property (PORT_POWER_SWITCHED |-> POWER_SWITCHES)
        else $error("port power switched without capability");

    // rule bit in the image says which routing scheme is live
    a_rule_bit: assert property (s_sp_read |=> DAT_O[7] == ROUTE_EXPLICIT)
        else $error("routing rule bit wrong");

    // top nibble of the high route word has no port behind it
    a_hi_top_zero: assert property (s_hi_read |=> DAT_O[31:28] == 4'h0)
        else $error("high route word top nibble not zero");

    // the high word stays hidden as well when routing is grouped
    a_hi_hidden: assert property (s_hi_read |=>
        ROUTE_EXPLICIT || DAT_O == 32'h00000000)
        else $error("high route word visible without explicit routing");

    // ****************************************
    // per-port routing checks
    // ****************************************
    // grouped routing only ever climbs through the companions in order;
    // unused ports must point nowhere so software cannot misread them
    for (genvar k = 0; k < 15; k++) begin : g_route_chk
        if (k >= PORTS_EFF) begin : g_unused
            a_unused_port: assert property (PORT_ROUTE[k*4 +: 4] == 4'h0)
                else $error("unused port has a route");
        end else if (!ROUTE_EXPLICIT && COMPANIONS != 0) begin : g_grouped
            // every used port lands on a companion that exists
            a_route_range: assert property (PORT_ROUTE[k*4 +: 4] < CC_F)
                else $error("port routed past last companion");
            if (k > 0) begin : g_order
                // consecutive groups: never back to a lower companion
                a_route_order: assert property (
                    PORT_ROUTE[k*4 +: 4] >= PORT_ROUTE[k*4-4 +: 4])
                    else $error("grouped routing out of order");
            end
        end else if (COMPANIONS == 0) begin : g_nocomp
            // no companion means no hand-off target at all
            a_route_none: assert property (PORT_ROUTE[k*4 +: 4] == 4'h0)
                else $error("port routed without companions");
        end
    end
endmodule // structural_parameters
`default_nettype wire

// ---- tb/ehci_structural_params_reg_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench: three configurations on one bus
// ****************************************
module ehci_structural_params_reg_test import sp_reg_pkg::*;;
    localparam int CC [3] = '{2, 2, 0};
    localparam int PP [3] = '{1, 2, 1};
    localparam bit RE [3] = '{1, 0, 0};
    localparam bit PW [3] = '{1, 0, 0};
    localparam int NP [3] = '{2, 4, 0};
    localparam word_t W_DFLT = {16'h0000, 4'h2, 4'h1, 1'h1, 2'h0, 1'h1, 4'h2};
    localparam word_t W_GRP = {16'h0000, 4'h2, 4'h2, 1'h0, 2'h0, 1'h0, 4'h4};
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    word_t dat_w = 32'h00000000;
    word_t dat [3];
    word_t r [3];
    logic ack [3];
    logic [2:0] handoff;
    logic [2:0] power;
    nibble_t cnt [3];
    logic [59:0] route [3];
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;

    // grouped and bare variants share the bus, so every input sees traffic
    for (genvar i = 0; i < 3; i++) begin : g_inst
        structural_parameters #(.COMPANIONS(CC[i]), .PORTS_PER(PP[i]), .ROUTE_EXPLICIT(RE[i]),
            .POWER_SWITCHES(PW[i]), .PORTS(NP[i])) u_dut (.CLK(clk), .RST_B(rst_b),
            .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w),
            .DAT_O(dat[i]), .ACK_O(ack[i]), .HANDOFF_EN(handoff[i]),
            .PORT_POWER_SWITCHED(power[i]), .PORT_REG_COUNT(cnt[i]), .PORT_ROUTE(route[i]));
    end

    // clock and hang guard
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic cycle; ack sampled before the edge's own updates land
    task automatic xfer(input logic w, input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        dat_w <= 32'hffffffff;
        do begin
            @(posedge clk);
            n++;
        end while (ack[0] !== 1'h1 && n < 20);
        chk("ack seen", 1, ack[0]);
        for (int i = 0; i < 3; i++) r[i] = dat[i];
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clk);
        chk("ack pulse", 0, ack[0]);
    endtask

    task automatic summarize();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'h1;
        repeat (4) @(posedge clk);
        chk("handoff", 1, handoff[0]);
        chk("no handoff", 0, handoff[2]);
        chk("power sw", 1, power[0]);
        chk("no power sw", 0, power[1]);
        chk("port count", 2, cnt[0]);
        chk("grp count", 4, cnt[1]);
        chk("zero count", 0, cnt[2] == 4'h0);
        chk("route explicit", 60'h10, route[0]);
        chk("route grouped", 60'h1100, route[1]);
        chk("route none", 0, route[2]);
        $display("test status done");
        xfer(1'h0, 8'h04);
        chk("word dflt", W_DFLT, r[0]);
        chk("word grp", W_GRP, r[1]);
        chk("cc zero", 0, r[2][15:12]);
        chk("ports nonzero", 0, r[2][3:0] == 4'h0);
        $display("test read done");
        xfer(1'h1, 8'h04);
        chk("write no data", 0, r[0]);
        xfer(1'h0, 8'h04);
        chk("word kept", W_DFLT, r[0]);
        $display("test write done");
        xfer(1'h0, 8'h0c);
        chk("route lo", 32'h00000010, r[0]);
        chk("route lo off", 0, r[1]);
        xfer(1'h0, 8'h10);
        chk("route hi", 0, r[0]);
        xfer(1'h0, 8'h08);
        chk("unmapped", 0, r[0]);
        $display("test route done");
        summarize();
    end
endmodule // ehci_structural_params_reg_test
`default_nettype wire
